// ===== common/rgs_pkg.sv
// Shared types and constants for the rail group sequencer
package rgs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_TIME_NS = 1000000;
  localparam int unsigned MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W = 20;
  localparam int unsigned GAP_COUNT = 7;
  localparam logic [2:0] GRP_FIRST = 3'h0;
  localparam logic [2:0] GRP_LAST = 3'h7;
  localparam logic [3:0] GAP_MS_SEL0 = 4'h1;
  localparam logic [3:0] GAP_MS_SEL1 = 4'h2;
  localparam logic [3:0] GAP_MS_SEL2 = 4'h4;
  localparam logic [3:0] GAP_MS_SEL3 = 4'ha;
  localparam int unsigned RAIL_MAIN_BUCK = 0;
  localparam int unsigned RAIL_DDR = 1;
  localparam int unsigned GPIO_RAILS = 3;
  localparam logic RST_OUT_RESET = 1'b0;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_UP = 3'b001,
    ST_ON = 3'b010,
    ST_DOWN = 3'b011,
    ST_SLP_DN = 3'b100,
    ST_SLEEP = 3'b101,
    ST_SLP_UP = 3'b110
  } rgs_state_t;

  typedef struct packed {
    logic rail_sequence_include;
    logic [2:0] power_up_group;
    logic sleep_keep_on;
    logic pin_ctrl;
    logic enable_pin_choice;
  } rgs_rail_cfg_t;
endpackage

// ===== src/rgs_sequencer.sv
// Rail group sequencer: ordered rail enables with gap delays and pin handoff
`timescale 1ns/1ps
// Functional notes
// - Only rails with their include bit set are switched by group sequencing.
// - Power-up enables groups in ascending order from group 0 to group 7.
// - Power-down disables groups in descending order from group 7 to group 0.
// - All rails with the same group code switch in the same step.
// - Each of seven gap enable bits inserts a wait between group n and n+1, none when clear.
// - Gap select 00, 01, 10, 11 waits 1 ms, 2 ms, 4 ms and 10 ms, set per gap.
// - A rail with sleep-keep set stays enabled throughout SLEEP.
// - A rail with sleep-keep clear goes off entering SLEEP and on leaving it, by sleep group.
// - On start-up from OFF each sleep group is loaded with its power-up group.
// - Selecting a pin's enable function forces that pin to output direction.
// - With the main buck split, its fields drive phase A and the DDR fields drive phase B.
// - A pin-controlled rail follows its enable pin once the reset output is high.
// - Choice bit picks pin A on zero and pin B on one, masked while reset output is low.
// - On the first reset output rise the sequencer still drives, the pin takes over next.
module rgs_sequencer #(
  parameter int unsigned NUM_RAILS = 19,
  parameter int unsigned MS_CYCLES = rgs_pkg::MS_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic power_on_req,
  input wire logic sleep_req,
  input wire rgs_pkg::rgs_rail_cfg_t [NUM_RAILS-1:0] rail_cfg,
  input wire logic [rgs_pkg::GAP_COUNT-1:0] gap_delay_enable,
  input wire logic [rgs_pkg::GAP_COUNT-1:0][1:0] gap_delay_select,
  input wire logic [NUM_RAILS-1:0] sleep_group_wr,
  input wire logic [NUM_RAILS-1:0][2:0] sleep_group_wdata,
  input wire logic main_buck_split,
  input wire logic [rgs_pkg::GPIO_RAILS-1:0] gpio_func_sel,
  input wire logic [rgs_pkg::GPIO_RAILS-1:0] gpio_dir_sw,
  input wire logic enable_pin_a,
  input wire logic enable_pin_b,
  output rgs_pkg::rgs_state_t state_ff,
  output logic [NUM_RAILS-1:0] rail_enable_ff,
  output logic [NUM_RAILS-1:0][2:0] sleep_group_ff,
  output logic main_buck_phase_a_ff,
  output logic main_buck_phase_b_ff,
  output logic ddr_rail_enable_ff,
  output logic [rgs_pkg::GPIO_RAILS-1:0] gpio_dir_out_ff,
  output logic system_reset_out_n_ff
);

  logic [2:0] grp_ff;
  logic wait_ff;
  logic [3:0] ms_left_ff;
  logic [rgs_pkg::TICK_W-1:0] tick_cnt_ff;
  logic [NUM_RAILS-1:0] seq_en_ff;
  logic pin_active_ff;
  logic [NUM_RAILS-1:0] act_mask;
  logic [NUM_RAILS-1:0] incl_mask;
  logic [NUM_RAILS-1:0] keep_mask;
  logic [NUM_RAILS-1:0] nxt_rail_en;
  logic [NUM_RAILS-1:0][2:0] pug_vec;
  logic in_seq;
  logic going_up;
  logic sleep_mode;
  logic step;
  logic last;
  logic [2:0] gap_idx;
  logic gap_on;
  logic tick;
  logic wait_done;
  logic [3:0] gap_len;

  function automatic logic [3:0] gap_ms(input logic [1:0] sel);
    logic [3:0] ms;
    ms = rgs_pkg::GAP_MS_SEL0;
    unique case (sel)
      2'h0: ms = rgs_pkg::GAP_MS_SEL0;
      2'h1: ms = rgs_pkg::GAP_MS_SEL1;
      2'h2: ms = rgs_pkg::GAP_MS_SEL2;
      2'h3: ms = rgs_pkg::GAP_MS_SEL3;
    endcase
    return ms;
  endfunction

  function automatic logic grp_hit(input rgs_pkg::rgs_rail_cfg_t cfg, input logic [2:0] sgrp,
                                   input logic [2:0] g, input logic slp);
    logic in_grp;
    in_grp = slp ? (!cfg.sleep_keep_on && (sgrp == g)) : (cfg.power_up_group == g);
    return cfg.rail_sequence_include && in_grp;
  endfunction

  always_comb
  begin
    in_seq = (state_ff == rgs_pkg::ST_UP) || (state_ff == rgs_pkg::ST_DOWN) ||
             (state_ff == rgs_pkg::ST_SLP_DN) || (state_ff == rgs_pkg::ST_SLP_UP);
    going_up = (state_ff == rgs_pkg::ST_UP) || (state_ff == rgs_pkg::ST_SLP_UP);
    sleep_mode = (state_ff == rgs_pkg::ST_SLP_DN) || (state_ff == rgs_pkg::ST_SLP_UP);
    step = in_seq && !wait_ff;
    last = going_up ? (grp_ff == rgs_pkg::GRP_LAST) : (grp_ff == rgs_pkg::GRP_FIRST);
    gap_idx = last ? 3'h0 : (going_up ? grp_ff : grp_ff - 3'h1);
    gap_on = !last && gap_delay_enable[gap_idx];
    gap_len = gap_ms(gap_delay_select[gap_idx]);
    tick = (tick_cnt_ff == rgs_pkg::TICK_W'(MS_CYCLES - 1));
    wait_done = wait_ff && tick && (ms_left_ff == 4'h1);
    for (int i = 0; i < NUM_RAILS; i++)
    begin
      act_mask[i] = grp_hit(rail_cfg[i], sleep_group_ff[i], grp_ff, sleep_mode);
      incl_mask[i] = rail_cfg[i].rail_sequence_include;
      keep_mask[i] = rail_cfg[i].sleep_keep_on;
      pug_vec[i] = rail_cfg[i].power_up_group;
      nxt_rail_en[i] = seq_en_ff[i];
      if (rail_cfg[i].pin_ctrl && pin_active_ff && system_reset_out_n_ff)
      begin
        nxt_rail_en[i] = rail_cfg[i].enable_pin_choice ? enable_pin_b : enable_pin_a;
      end
    end
  end

  // Operating state and group walk
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_ff <= rgs_pkg::ST_OFF;
      grp_ff <= rgs_pkg::GRP_FIRST;
    end
    else if (clk_en)
    begin
      unique case (state_ff)
        rgs_pkg::ST_OFF:
        begin
          if (power_on_req)
          begin
            state_ff <= rgs_pkg::ST_UP;
            grp_ff <= rgs_pkg::GRP_FIRST;
          end
        end
        rgs_pkg::ST_ON, rgs_pkg::ST_SLEEP:
        begin
          if (!power_on_req)
          begin
            state_ff <= rgs_pkg::ST_DOWN;
            grp_ff <= rgs_pkg::GRP_LAST;
          end
          else if (sleep_req && state_ff == rgs_pkg::ST_ON)
          begin
            state_ff <= rgs_pkg::ST_SLP_DN;
            grp_ff <= rgs_pkg::GRP_LAST;
          end
          else if (!sleep_req && state_ff == rgs_pkg::ST_SLEEP)
          begin
            state_ff <= rgs_pkg::ST_SLP_UP;
            grp_ff <= rgs_pkg::GRP_FIRST;
          end
        end
        default:
        begin
          if (step && last)
          begin
            unique case (state_ff)
              rgs_pkg::ST_DOWN: state_ff <= rgs_pkg::ST_OFF;
              rgs_pkg::ST_SLP_DN: state_ff <= rgs_pkg::ST_SLEEP;
              default: state_ff <= rgs_pkg::ST_ON;
            endcase
          end
          else if ((step && !gap_on) || wait_done)
          begin
            grp_ff <= going_up ? grp_ff + 3'h1 : grp_ff - 3'h1;
          end
        end
      endcase
    end
  end

  // Millisecond timebase and gap wait
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      wait_ff <= 1'b0;
      ms_left_ff <= 4'h0;
      tick_cnt_ff <= '0;
    end
    else if (clk_en)
    begin
      if (step && !last && gap_on)
      begin
        wait_ff <= 1'b1;
        ms_left_ff <= gap_len;
        tick_cnt_ff <= '0;
      end
      else if (wait_ff)
      begin
        tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
        if (tick)
        begin
          ms_left_ff <= ms_left_ff - 4'h1;
        end
        if (wait_done)
        begin
          wait_ff <= 1'b0;
        end
      end
    end
  end

  // Sequencer rail enables
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      seq_en_ff <= '0;
    end
    else if (clk_en && step)
    begin
      seq_en_ff <= going_up ? (seq_en_ff | act_mask) : (seq_en_ff & ~act_mask);
    end
  end

  // Sleep groups mirror the power-up groups on each start-up
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      sleep_group_ff <= '0;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < NUM_RAILS; i++)
      begin
        if (state_ff == rgs_pkg::ST_OFF && power_on_req)
        begin
          sleep_group_ff[i] <= rail_cfg[i].power_up_group;
        end
        else if (sleep_group_wr[i])
        begin
          sleep_group_ff[i] <= sleep_group_wdata[i];
        end
      end
    end
  end

  // Reset output and enable pin handoff
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      system_reset_out_n_ff <= rgs_pkg::RST_OUT_RESET;
      pin_active_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_ff == rgs_pkg::ST_UP && step && last)
      begin
        system_reset_out_n_ff <= 1'b1;
      end
      else if (state_ff == rgs_pkg::ST_DOWN)
      begin
        system_reset_out_n_ff <= 1'b0;
      end
      pin_active_ff <= system_reset_out_n_ff && !(state_ff == rgs_pkg::ST_DOWN);
    end
  end

  // Pin outputs
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rail_enable_ff <= '0;
      main_buck_phase_a_ff <= 1'b0;
      main_buck_phase_b_ff <= 1'b0;
      ddr_rail_enable_ff <= 1'b0;
      gpio_dir_out_ff <= '0;
    end
    else if (clk_en)
    begin
      rail_enable_ff <= nxt_rail_en;
      main_buck_phase_a_ff <= nxt_rail_en[rgs_pkg::RAIL_MAIN_BUCK];
      main_buck_phase_b_ff <= main_buck_split ? nxt_rail_en[rgs_pkg::RAIL_DDR] :
                              nxt_rail_en[rgs_pkg::RAIL_MAIN_BUCK];
      ddr_rail_enable_ff <= main_buck_split ? 1'b0 : nxt_rail_en[rgs_pkg::RAIL_DDR];
      gpio_dir_out_ff <= gpio_func_sel | gpio_dir_sw;
    end
  end

  a_include_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en |=> ((seq_en_ff & ~$past(seq_en_ff) & ~$past(incl_mask)) == '0))
    else $error("Excluded rail was switched on");
  a_up_start: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_ff == rgs_pkg::ST_UP && $past(state_ff) == rgs_pkg::ST_OFF) |-> grp_ff == 3'h0)
    else $error("Power-up did not start at group 0");
  a_up_order: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_ff == rgs_pkg::ST_UP && $past(state_ff) == rgs_pkg::ST_UP) |-> grp_ff >= $past(grp_ff))
    else $error("Power-up group went backwards");
  a_down_order: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_ff == rgs_pkg::ST_DOWN && $past(state_ff) == rgs_pkg::ST_DOWN) |->
    grp_ff <= $past(grp_ff))
    else $error("Power-down group went forwards");
  a_same_group: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && step && going_up) |=> ((seq_en_ff & $past(act_mask)) == $past(act_mask)))
    else $error("Rails of one group did not switch together");
  a_no_gap: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && state_ff == rgs_pkg::ST_UP && step && !last && !gap_on) |=>
    grp_ff == $past(grp_ff) + 3'h1)
    else $error("Group step stalled without a gap delay");
  a_gap_value: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && step && gap_on) |=> wait_ff && ms_left_ff == $past(gap_len) &&
    (ms_left_ff == 4'h1 || ms_left_ff == 4'h2 || ms_left_ff == 4'h4 || ms_left_ff == 4'ha))
    else $error("Gap delay loaded a wrong length");
  a_sleep_keep: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_ff == rgs_pkg::ST_SLP_DN) |=> ((~seq_en_ff & $past(seq_en_ff) & $past(keep_mask)) == '0))
    else $error("Kept rail dropped on sleep entry");
  a_sleep_default: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && state_ff == rgs_pkg::ST_OFF && power_on_req) |=> sleep_group_ff == $past(pug_vec))
    else $error("Sleep groups not copied on start-up");
  a_gpio_out: assert property (@(posedge mclk) disable iff (!reset_n)
    clk_en |=> ((gpio_dir_out_ff & $past(gpio_func_sel)) == $past(gpio_func_sel)))
    else $error("Enable pin not forced to output");
  a_split_phase: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && main_buck_split) |=> main_buck_phase_b_ff == rail_enable_ff[rgs_pkg::RAIL_DDR])
    else $error("Phase B not driven by DDR rail");
  a_pin_mask: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && !system_reset_out_n_ff) |=> rail_enable_ff == $past(seq_en_ff))
    else $error("Enable pin acted while reset output low");
  a_first_rise: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && $rose(system_reset_out_n_ff)) |=> rail_enable_ff == $past(seq_en_ff))
    else $error("Pin took over on first reset rise");

  c_power_up: cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(system_reset_out_n_ff));
  c_sleep: cover property (@(posedge mclk) disable iff (!reset_n)
    state_ff == rgs_pkg::ST_SLEEP);
  c_gap_wait: cover property (@(posedge mclk) disable iff (!reset_n) wait_done);
  c_handoff: cover property (@(posedge mclk) disable iff (!reset_n)
    pin_active_ff && system_reset_out_n_ff);

endmodule

// ===== test/rgs_pin_model.sv
// Model of the external logic that drives the two regulator enable pins
`timescale 1ns/1ps
module rgs_pin_model (
  input wire logic mclk,
  input wire logic want_a,
  input wire logic want_b,
  output logic enable_pin_a,
  output logic enable_pin_b
);
  initial
  begin
    enable_pin_a = 1'b0;
    enable_pin_b = 1'b0;
  end

  // Pins move only just after a falling edge, away from the sampling edge
  always @(negedge mclk)
  begin
    enable_pin_a <= want_a;
    enable_pin_b <= want_b;
  end
endmodule

// ===== test/tb_rail_group_sequencer.sv
// Self-checking testbench for the rail group sequencer
`timescale 1ns/1ps
`define CHK(g, e) chk((g) === (e), `__LINE__)
module tb_rail_group_sequencer;
  localparam int NR = 5;
  localparam int MSC = 4;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic power_on_req = 1'b0;
  logic sleep_req = 1'b0;
  logic clk_en = 1'b1;
  rgs_pkg::rgs_rail_cfg_t [NR-1:0] rail_cfg;
  logic [rgs_pkg::GAP_COUNT-1:0] gap_en = 7'h03;
  logic [rgs_pkg::GAP_COUNT-1:0][1:0] gap_sel = 14'h0000;
  logic [NR-1:0] sg_wr = 5'h00;
  logic [NR-1:0][2:0] sg_wdata = 15'h0000;
  logic split = 1'b0;
  logic [2:0] func_sel = 3'h5;
  logic [2:0] dir_sw = 3'h2;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic pin_a;
  logic pin_b;
  rgs_pkg::rgs_state_t state;
  logic [NR-1:0] rail_en;
  logic [NR-1:0][2:0] sleep_grp;
  logic phase_a, phase_b, ddr_en, rst_out;
  logic [2:0] gpio_dir;
  logic [NR-1:0] prev = 5'h00;
  logic keep_fell = 1'b0;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int rise_t[NR];
  int fall_t[NR];

  rgs_sequencer #(.NUM_RAILS(NR), .MS_CYCLES(MSC)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .power_on_req(power_on_req),
    .sleep_req(sleep_req), .rail_cfg(rail_cfg), .gap_delay_enable(gap_en),
    .gap_delay_select(gap_sel), .sleep_group_wr(sg_wr), .sleep_group_wdata(sg_wdata),
    .main_buck_split(split), .gpio_func_sel(func_sel), .gpio_dir_sw(dir_sw),
    .enable_pin_a(pin_a), .enable_pin_b(pin_b), .state_ff(state),
    .rail_enable_ff(rail_en), .sleep_group_ff(sleep_grp), .main_buck_phase_a_ff(phase_a),
    .main_buck_phase_b_ff(phase_b), .ddr_rail_enable_ff(ddr_en),
    .gpio_dir_out_ff(gpio_dir), .system_reset_out_n_ff(rst_out));

  rgs_pin_model i_pins (.mclk(mclk), .want_a(want_a), .want_b(want_b),
    .enable_pin_a(pin_a), .enable_pin_b(pin_b));

  always #50 mclk = ~mclk;

  // Records the cycle of every rail edge
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    prev <= rail_en;
    for (int i = 0; i < NR; i++)
    begin
      if (rail_en[i] && !prev[i]) rise_t[i] = cyc;
      if (!rail_en[i] && prev[i]) fall_t[i] = cyc;
    end
    if (state == rgs_pkg::ST_SLEEP && !rail_en[1]) keep_fell = 1'b1;
  end

  task automatic chk(input bit ok, input int ln);
    checks_done++;
    if (!ok)
    begin
      mismatches++;
      $display("[FAIL] t=%0t compare at line %0d", $time, ln);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wait_state(input rgs_pkg::rgs_state_t s);
    int n;
    n = 0;
    while (state !== s && n < 500)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 500)
    begin
      mismatches++;
      $display("[FAIL] t=%0t state wait timed out", $time);
    end
  endtask

  task automatic clr();
    for (int i = 0; i < NR; i++)
    begin
      rise_t[i] = -1;
      fall_t[i] = -1;
    end
  endtask

  // Rails 0 and 3 may hand over to pins A and B; rail 4 is left out of sequencing
  task automatic set_cfg(input logic pc);
    rail_cfg[0] = '{1'b1, 3'h0, 1'b0, pc, 1'b0};
    rail_cfg[1] = '{1'b1, 3'h2, 1'b1, 1'b0, 1'b0};
    rail_cfg[2] = '{1'b1, 3'h2, 1'b0, 1'b0, 1'b0};
    rail_cfg[3] = '{1'b1, 3'h7, 1'b1, pc, 1'b1};
    rail_cfg[4] = '{1'b0, 3'h4, 1'b0, 1'b0, 1'b0};
  endtask

  task automatic power_up(input logic [1:0] s0, input logic [1:0] s1, input int m0, input int m1);
    gap_sel[0] = s0;
    gap_sel[1] = s1;
    clr();
    power_on_req = 1'b1;
    wait_state(rgs_pkg::ST_ON);
    repeat (4) @(negedge mclk);
    `CHK(rise_t[1] - rise_t[0], 2 + (m0 + m1) * MSC);
    `CHK(rise_t[1] - rise_t[0] > 2, 1'b1);
    `CHK(rise_t[2], rise_t[1]);
    `CHK(rise_t[3] - rise_t[1], 5);
    `CHK(rise_t[4], -1);
    `CHK(rst_out, 1'b1);
  endtask

  task automatic power_down();
    clr();
    power_on_req = 1'b0;
    wait_state(rgs_pkg::ST_OFF);
    repeat (4) @(negedge mclk);
    `CHK(fall_t[3] < fall_t[1], 1'b1);
    `CHK(fall_t[2], fall_t[1]);
    `CHK(fall_t[1] < fall_t[0], 1'b1);
    `CHK(rst_out, 1'b0);
  endtask

  initial
  begin
    set_cfg(1'b1);
    clr();
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    // Gap codes 00 and 10, gpio rail handed to pin B
    power_up(2'h0, 2'h2, 1, 4);
    `CHK(rail_en[3], 1'b0);
    `CHK(rail_en[0], 1'b0);
    for (int i = 0; i < 4; i++)
      `CHK(sleep_grp[i], rail_cfg[i].power_up_group);
    `CHK(gpio_dir, 3'h7);
    want_b = 1'b1;
    repeat (3) @(negedge mclk);
    `CHK(rail_en[3], 1'b1);
    want_a = 1'b1;
    want_b = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK(rail_en[3], 1'b0);
    `CHK(rail_en[0], 1'b1);
    want_b = 1'b1;
    split = 1'b1;
    repeat (3) @(negedge mclk);
    `CHK(ddr_en, 1'b0);
    `CHK(phase_b, 1'b1);
    `CHK(phase_a, 1'b1);
    clk_en = 1'b0;
    split = 1'b0;
    repeat (3) @(negedge mclk);
    `CHK(ddr_en, 1'b0);
    clk_en = 1'b1;
    repeat (3) @(negedge mclk);
    `CHK(ddr_en, 1'b1);
    power_down();
    $display("test one done");
    // Gap codes 01 and 11, then a custom sleep walk
    set_cfg(1'b0);
    power_up(2'h1, 2'h3, 2, 10);
    sg_wdata[0] = 3'h7;
    sg_wdata[2] = 3'h0;
    sg_wr = 5'h05;
    @(negedge mclk);
    sg_wr = 5'h00;
    @(negedge mclk);
    `CHK(sleep_grp[0], 3'h7);
    clr();
    sleep_req = 1'b1;
    wait_state(rgs_pkg::ST_SLEEP);
    repeat (3) @(negedge mclk);
    `CHK(fall_t[0] < fall_t[2], 1'b1);
    `CHK(rail_en[1], 1'b1);
    split = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK(phase_b, 1'b1);
    `CHK(phase_a, 1'b0);
    split = 1'b0;
    clr();
    sleep_req = 1'b0;
    wait_state(rgs_pkg::ST_ON);
    repeat (4) @(negedge mclk);
    `CHK(rise_t[2] < rise_t[0], 1'b1);
    `CHK(keep_fell, 1'b0);
    power_down();
    $display("test two done");
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    end_sim();
  end
endmodule
